// File: asc_pkg.sv
// shared types and constants of the arithmetic, shift and compare unit
package asc_pkg;
	localparam int WORD_W = 30;
	localparam int CNT_W = 6;
	localparam int MAG_W = WORD_W - 1;
	localparam int ROOT_W = 15;
	localparam int LATENCY_CYC = 1;
	localparam logic [WORD_W-1:0] WORD_RESET = 30'h0000_0000;
	localparam logic [WORD_W-1:0] NULL_WORD = 30'h0a00_0000;
	localparam logic [2:0] IDX_FIRST = 3'h1;
	localparam logic [2:0] IDX_LAST = 3'h7;

	typedef logic [WORD_W-1:0] asc_word_t;

	typedef enum logic [3:0] {
		OP_NULL     = 4'b0000,
		OP_ZERO     = 4'b0001,
		OP_RSHIFT   = 4'b0010,
		OP_LSHIFT   = 4'b0011,
		OP_ADD      = 4'b0100,
		OP_SUB      = 4'b0101,
		OP_PRODUCT  = 4'b0110,
		OP_DIVIDE   = 4'b0111,
		OP_SQRT     = 4'b1000,
		OP_MAG_TEST = 4'b1001,
		OP_MASK_CMP = 4'b1010
	} asc_op_t;

	typedef enum logic [2:0] {
		SEL_RES    = 3'b000,
		SEL_MULT   = 3'b001,
		SEL_DOUBLE = 3'b010,
		SEL_MASKED = 3'b011,
		SEL_INDEX  = 3'b100,
		SEL_MEMORY = 3'b101
	} asc_sel_t;

	typedef enum logic [4:0] {
		SK_NEVER     = 5'b00000,
		SK_ALWAYS    = 5'b00001,
		SK_MULT_POS  = 5'b00010,
		SK_MULT_NEG  = 5'b00011,
		SK_RES_ZERO  = 5'b00100,
		SK_RES_NZ    = 5'b00101,
		SK_RES_POS   = 5'b00110,
		SK_RES_NEG   = 5'b00111,
		SK_OVF       = 5'b01000,
		SK_NO_OVF    = 5'b01001,
		SK_LEFT_NZ   = 5'b01010,
		SK_LEFT_ZERO = 5'b01011,
		SK_MULT_ZERO = 5'b01100,
		SK_MULT_NZ   = 5'b01101,
		SK_Y_BELOW   = 5'b01110,
		SK_Y_ABOVE   = 5'b01111,
		SK_Y_WINDOW  = 5'b10000,
		SK_Y_OUTSIDE = 5'b10001
	} asc_skip_t;

	typedef struct packed {
		asc_op_t   op;
		asc_sel_t  sel;
		logic [2:0] idx;
		asc_skip_t cond;
		asc_word_t operand;
	} asc_req_t;
endpackage

// File: asc_seq_model.sv
// instruction sequencer model that feeds requests into the unit
`timescale 1ns/1ps
`default_nettype none
module asc_seq_model (
	input  wire logic        clk,
	output logic             req_valid,
	output asc_pkg::asc_req_t req
);
	import asc_pkg::*;
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// held over exactly one rising edge; caller reads the answer on return
	task automatic send(input asc_op_t op, input asc_sel_t sel, input asc_skip_t cond,
		input asc_word_t opnd);
		@(negedge clk);
		req_valid = 1'b1;
		req = '{op: op, sel: sel, idx: IDX_FIRST, cond: cond, operand: opnd};
		@(negedge clk);
		req_valid = 1'b0;
		// idle fields toggle so a stale value never passes for a request
		req = ~req;
	endtask
endmodule // asc_seq_model
`default_nettype wire

// File: asc_unit.sv
// arithmetic, shift and compare execution unit of a 30-bit word machine
// How it works
// (RULE1) null instruction changes nothing; execution just moves on
// (RULE2) zeroing clears memory word, result, multiplier or index register one..seven
// (RULE3) right shift fills with original sign, drops low bits
// (RULE4) shift count is the operand's low six bits only
// (RULE5) left shift is circular, top bits come back at the bottom
// (RULE6) shifts work on result, multiplier, or both joined as 60 bits
// (RULE7) add into result or multiplier, or masked product into result
// (RULE8) subtract from result or multiplier, or masked product from result
// (RULE9) masked product is operand AND multiplier register
// (RULE10) multiply multiplier by operand, double product across joined registers
// (RULE11) multiply on magnitudes, complement product when signs differ
// (RULE12) multiply skip test sees product before complement
// (RULE13) divide joined pair by operand: quotient to multiplier, remainder to result
// (RULE14) remainder takes the quotient's sign
// (RULE15) divide flags overflow; skips on overflow, none, always, never, result tests
// (RULE16) divide skip sees a positive result register
// (RULE17) square root of multiplier magnitude, remainder to result, skip on remainder
// (RULE18) register compare keeps registers, skips when condition holds
// (RULE19) conditions: below-or-equal, above, window, outside window
// (RULE20) window compare uses both registers as separate 30-bit values
// (RULE21) masked compare tests result against masked product, keeps registers
// (RULE22) masked compare tests result minus masked product, then restores
// (RULE23) normal skips: never, always, multiplier sign, result zero/nonzero/sign
// (RULE24) add/subtract on multiplier tests multiplier for zero and nonzero
// (RULE25) all words are 30 bits with sign in the top bit
`timescale 1ns/1ps
`default_nettype none
module asc_unit (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  req_valid,
	input  wire asc_pkg::asc_req_t     req,
	output logic                       req_ready,
	output logic                       done,
	output logic                       skip,
	output logic                       overflow,
	output logic                       mem_clear,
	output asc_pkg::asc_word_t         res_reg,
	output asc_pkg::asc_word_t         mult_reg,
	output var asc_pkg::asc_word_t [7:1] index_regs
);
	import asc_pkg::*;

	// ones' complement helpers
	function automatic asc_word_t oc_add(input asc_word_t x, input asc_word_t b);
		logic [WORD_W:0] s;
		s = {1'b0, x} + {1'b0, b};
		return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
	endfunction

	function automatic logic [MAG_W-1:0] mag(input asc_word_t x);
		return x[WORD_W-1] ? ~x[MAG_W-1:0] : x[MAG_W-1:0];
	endfunction

	function automatic logic signed [WORD_W:0] sval(input asc_word_t x);
		logic signed [WORD_W:0] m;
		m = $signed({2'b00, mag(x)});
		return x[WORD_W-1] ? -m : m;
	endfunction

	// both zeros count as zero
	function automatic logic is_zero(input asc_word_t x);
		return (x == '0) || (&x);
	endfunction

	function automatic logic [ROOT_W-1:0] isqrt(input logic [MAG_W-1:0] m);
		logic [ROOT_W-1:0] r;
		logic [ROOT_W-1:0] t;
		logic [WORD_W-1:0] sq;
		r = '0;
		for (int i = ROOT_W - 1; i >= 0; i--) begin
			t = r | (15'h0001 << i);
			sq = t * t;
			if (sq <= {1'b0, m})
				r = t;
		end
		return r;
	endfunction

	function automatic logic skip_eval(input asc_skip_t c, input asc_word_t av,
			input asc_word_t qv, input logic ovf, input logic hit, input logic zq);
		asc_word_t zv;
		zv = zq ? qv : av;
		case (c)
			SK_NEVER:     return 1'b0;
			SK_ALWAYS:    return 1'b1;
			SK_MULT_POS:  return !qv[WORD_W-1];
			SK_MULT_NEG:  return qv[WORD_W-1];
			SK_RES_ZERO:  return is_zero(zv); // RULE24
			SK_RES_NZ:    return !is_zero(zv); // RULE24
			SK_RES_POS:   return !av[WORD_W-1];
			SK_RES_NEG:   return av[WORD_W-1];
			SK_OVF:       return ovf;
			SK_NO_OVF:    return !ovf;
			SK_LEFT_NZ:   return !is_zero(av);
			SK_LEFT_ZERO: return is_zero(av);
			SK_MULT_ZERO: return is_zero(qv);
			SK_MULT_NZ:   return !is_zero(qv);
			SK_Y_BELOW, SK_Y_ABOVE, SK_Y_WINDOW, SK_Y_OUTSIDE: return hit;
			default:      return 1'b0;
		endcase
	endfunction

	asc_word_t                a_q, a_d; // RULE25
	asc_word_t                q_q, q_d;
	asc_word_t [7:1]          idx_q, idx_d;
	logic                     done_q, skip_q, skip_d, ovf_q, ovf_d, clr_q, clr_d;
	asc_req_t                 last_q;

	// operand decode
	wire asc_word_t           y       = req.operand;
	wire logic [CNT_W-1:0]    cnt     = req.operand[CNT_W-1:0]; // RULE4
	// rotations wrap the count so one doubled word covers every amount
	wire logic [CNT_W-1:0]    cnt30   = cnt % 6'd30;
	wire logic [CNT_W-1:0]    cnt60   = cnt % 6'd60;
	wire logic [2*WORD_W-1:0] dbl     = {a_q, q_q};
	wire asc_word_t           lp      = y & q_q; // RULE9

	// add and subtract
	wire asc_word_t           add_a   = oc_add(a_q, y); // RULE7
	wire asc_word_t           add_q   = oc_add(q_q, y);
	wire asc_word_t           add_lp  = oc_add(a_q, lp);
	wire asc_word_t           sub_a   = oc_add(a_q, ~y); // RULE8
	wire asc_word_t           sub_q   = oc_add(q_q, ~y);
	wire asc_word_t           sub_lp  = oc_add(a_q, ~lp); // RULE22

	// shifts; a right-shift count past the width leaves only sign copies
	wire asc_word_t           rsh_a   = $signed(a_q) >>> cnt; // RULE3
	wire asc_word_t           rsh_q   = $signed(q_q) >>> cnt;
	wire logic [2*WORD_W-1:0] rsh_aq  = $signed(dbl) >>> cnt; // RULE6
	wire logic [2*WORD_W-1:0] rot_a   = {a_q, a_q} << cnt30; // RULE5
	wire logic [2*WORD_W-1:0] rot_q   = {q_q, q_q} << cnt30;
	wire logic [4*WORD_W-1:0] rot_aq  = {dbl, dbl} << cnt60;

	// multiply on magnitudes
	wire logic [MAG_W-1:0]    my      = mag(y);
	wire logic [MAG_W-1:0]    mq      = mag(q_q);
	wire logic [2*WORD_W-1:0] prod    = {2'b00, mq} * {31'h0, my}; // RULE10
	wire logic                sgn_dif = q_q[WORD_W-1] ^ y[WORD_W-1];
	wire logic [2*WORD_W-1:0] prod_fin = sgn_dif ? ~prod : prod; // RULE11

	// divide; a zero divisor or a quotient past 29 bits is a divide fault
	wire logic [2*WORD_W-2:0] dvd     = dbl[2*WORD_W-1] ? ~dbl[2*WORD_W-2:0]
	                                                    : dbl[2*WORD_W-2:0];
	wire logic                dvs_z   = (my == '0);
	wire logic [2*WORD_W-2:0] dvs     = {30'h0, (dvs_z ? 29'h1 : my)};
	wire logic [2*WORD_W-2:0] quot_f  = dvd / dvs; // RULE13
	wire logic [2*WORD_W-2:0] rem_f   = dvd % dvs;
	wire logic                div_ovf = dvs_z || (|quot_f[2*WORD_W-2:MAG_W]); // RULE15
	wire logic                q_neg   = dbl[2*WORD_W-1] ^ y[WORD_W-1];
	wire asc_word_t           quot_w  = {1'b0, quot_f[MAG_W-1:0]};
	wire asc_word_t           rem_w   = {1'b0, rem_f[MAG_W-1:0]};

	// square root of the multiplier magnitude
	wire logic [ROOT_W-1:0]   root    = isqrt(mq); // RULE17
	wire logic [WORD_W-1:0]   root_sq = root * root;
	wire logic [MAG_W-1:0]    sq_rem  = mq - root_sq[MAG_W-1:0];

	// compares on signed values, registers kept separate
	wire logic signed [WORD_W:0] vy   = sval(y);
	wire logic signed [WORD_W:0] va   = sval(a_q);
	wire logic signed [WORD_W:0] vq   = sval(q_q);
	wire logic                vreg_le = (req.sel == SEL_MULT) ? (vy <= vq) : (vy <= va);
	wire logic                win     = (vq >= vy) && (vy > va); // RULE20
	wire logic                cmp_hit = (req.cond == SK_Y_BELOW)  ? vreg_le :
	                                    (req.cond == SK_Y_ABOVE)  ? !vreg_le :
	                                    (req.cond == SK_Y_WINDOW) ? win :
	                                    (req.cond == SK_Y_OUTSIDE) ? !win : 1'b0; // RULE19

	// index zero is no register; clearing it is dropped quietly
	wire logic                idx_ok  = (req.idx >= IDX_FIRST) && (req.idx <= IDX_LAST);

	always_comb begin
		asc_word_t ea;
		asc_word_t eq;
		logic      zq;
		ea = a_q;
		eq = q_q;
		zq = 1'b0;
		a_d = a_q;
		q_d = q_q;
		idx_d = idx_q;
		ovf_d = 1'b0;
		clr_d = 1'b0;
		case (req.op)
			OP_NULL: begin
				a_d = a_q; // RULE1
			end
			OP_ZERO: begin
				case (req.sel) // RULE2
					SEL_RES:    a_d = WORD_RESET;
					SEL_MULT:   q_d = WORD_RESET;
					SEL_INDEX:  if (idx_ok) idx_d[req.idx] = WORD_RESET;
					SEL_MEMORY: clr_d = 1'b1;
					default:    a_d = a_q;
				endcase
			end
			OP_RSHIFT, OP_LSHIFT: begin
				case (req.sel) // RULE6
					SEL_RES:    a_d = (req.op == OP_RSHIFT) ? rsh_a : rot_a[2*WORD_W-1:WORD_W];
					SEL_MULT:   q_d = (req.op == OP_RSHIFT) ? rsh_q : rot_q[2*WORD_W-1:WORD_W];
					SEL_DOUBLE: {a_d, q_d} = (req.op == OP_RSHIFT) ? rsh_aq
					                         : rot_aq[4*WORD_W-1:2*WORD_W];
					default:    a_d = a_q;
				endcase
			end
			OP_ADD, OP_SUB: begin
				case (req.sel)
					SEL_MULT: begin
						q_d = (req.op == OP_ADD) ? add_q : sub_q;
						zq = 1'b1; // RULE24
					end
					SEL_MASKED: a_d = (req.op == OP_ADD) ? add_lp : sub_lp; // RULE7 RULE8
					default:    a_d = (req.op == OP_ADD) ? add_a : sub_a;
				endcase
			end
			OP_PRODUCT: begin
				{a_d, q_d} = prod_fin;
				{ea, eq} = prod; // RULE12
			end
			OP_DIVIDE: begin
				ovf_d = div_ovf;
				// a fault leaves the pair as it was
				if (!div_ovf) begin
					q_d = q_neg ? ~quot_w : quot_w;
					a_d = q_neg ? ~rem_w : rem_w; // RULE14
				end
				ea = rem_w; // RULE16
			end
			OP_SQRT: begin
				q_d = {15'h0, root};
				a_d = {1'b0, sq_rem};
			end
			OP_MAG_TEST: begin
				a_d = a_q; // RULE18
			end
			OP_MASK_CMP: begin
				// subtract-and-restore nets to nothing, only the test sees it
				ea = sub_lp; // RULE21 RULE22
			end
			default: a_d = a_q;
		endcase
		if (req.op == OP_ADD || req.op == OP_SUB || req.op == OP_ZERO ||
				req.op == OP_RSHIFT || req.op == OP_LSHIFT || req.op == OP_SQRT) begin
			ea = a_d;
			eq = q_d;
		end
		// a null never skips, whatever condition rides along
		skip_d = (req.op != OP_NULL) &&
		         skip_eval(req.cond, ea, eq, ovf_d, cmp_hit, zq); // RULE23
	end

	// the pair and index file move only on a taken request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			a_q <= WORD_RESET;
			q_q <= WORD_RESET;
			idx_q <= '0;
			done_q <= 1'b0;
			skip_q <= 1'b0;
			ovf_q <= 1'b0;
			clr_q <= 1'b0;
			last_q <= '0;
		end else begin
			done_q <= req_valid;
			skip_q <= req_valid && skip_d;
			clr_q <= req_valid && clr_d;
			if (req_valid) begin
				a_q <= a_d;
				q_q <= q_d;
				idx_q <= idx_d;
				ovf_q <= ovf_d;
				last_q <= req;
			end
		end
	end

	// single-cycle unit: always ready, answer one edge later
	assign req_ready = 1'b1;
	assign done = done_q;
	assign skip = skip_q;
	assign overflow = ovf_q;
	assign mem_clear = clr_q;
	assign res_reg = a_q;
	assign mult_reg = q_q;
	assign index_regs = idx_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	null_keeps_regs_a: assert property (done && last_q.op == OP_NULL |-> // RULE1
		a_q == $past(a_q) && q_q == $past(q_q) && !skip) else $error("null changed state");
	zero_clears_a: assert property (req_valid && req.op == OP_ZERO && req.sel == SEL_MULT // RULE2
		|=> q_q == '0 && a_q == $past(a_q)) else $error("zeroing wrong");
	rshift_fill_a: assert property (req_valid && req.op == OP_RSHIFT && req.sel == SEL_RES // RULE3 RULE4
		&& req.operand[5:0] >= 6'd30 |=> a_q == {30{$past(a_q[29])}}) else $error("sign fill");
	lshift_rotate_a: assert property (req_valid && req.op == OP_LSHIFT // RULE5 RULE6
		&& req.sel == SEL_DOUBLE |=> $countones({a_q, q_q}) == $countones($past({a_q, q_q})))
		else $error("rotate lost bits");
	mul_skip_pos_a: assert property (req_valid && req.op == OP_PRODUCT // RULE12
		&& req.cond inside {SK_RES_POS, SK_RES_NEG} |=> skip == ($past(req.cond) == SK_RES_POS))
		else $error("multiply skip");
	div_neg_never_a: assert property (req_valid && req.op == OP_DIVIDE // RULE16
		&& req.cond == SK_RES_NEG |=> !skip) else $error("divide negative skip");
	div_rem_sign_a: assert property (done && last_q.op == OP_DIVIDE && !overflow // RULE14
		|-> a_q[29] == q_q[29]) else $error("remainder sign");
	div_ovf_skip_a: assert property (done && last_q.op == OP_DIVIDE // RULE15
		&& last_q.cond == SK_OVF |-> skip == overflow) else $error("overflow skip");
	cmp_keeps_a: assert property (req_valid && req.op inside {OP_MAG_TEST, OP_MASK_CMP} // RULE18 RULE21
		|=> a_q == $past(a_q) && q_q == $past(q_q)) else $error("compare changed");
	sqrt_rem_skip_a: assert property (req_valid && req.op == OP_SQRT // RULE17
		&& req.cond == SK_LEFT_ZERO |=> skip == (a_q == '0)) else $error("sqrt skip");
	answer_next_a: assert property (req_valid |=> done ##1 (done == $past(req_valid)))
		else $error("done timing");

	// checks that reach past the main scenarios
	idx_zeroed_a: assert property (req_valid && req.op == OP_ZERO // RULE2
		&& req.sel == SEL_INDEX && idx_ok |=> index_regs[$past(req.idx)] == '0)
		else $error("index not cleared");
	mem_pulse_a: assert property (mem_clear |-> done && last_q.op == OP_ZERO // RULE2
		&& last_q.sel == SEL_MEMORY) else $error("stray memory clear");
	lshift_one_a: assert property (req_valid && req.op == OP_LSHIFT // RULE5
		&& req.sel == SEL_RES && req.operand[5:0] == 6'd1
		|=> a_q == {$past(a_q[28:0]), $past(a_q[29])}) else $error("rotate direction");
	mult_zero_test_a: assert property (done && last_q.op inside {OP_ADD, OP_SUB} // RULE24
		&& last_q.sel == SEL_MULT && last_q.cond == SK_RES_ZERO |-> skip == is_zero(q_q))
		else $error("multiplier zero test");
	sqrt_positive_a: assert property (done && last_q.op == OP_SQRT // RULE17
		|-> !a_q[WORD_W-1] && !q_q[WORD_W-1]) else $error("root sign");
	div_fault_keep_a: assert property (done && last_q.op == OP_DIVIDE && overflow // RULE15
		|-> a_q == $past(a_q) && q_q == $past(q_q)) else $error("fault changed regs");

	// main scenarios worth seeing at least once
	add_cover_c: cover property (req_valid && req.op == OP_ADD ##1 skip);
	div_fault_c: cover property (req_valid && req.op == OP_DIVIDE ##1 overflow);
	window_hit_c: cover property (req_valid && req.cond == SK_Y_WINDOW ##1 skip);
	mul_fix_c: cover property (req_valid && req.op == OP_PRODUCT && sgn_dif);
	mask_zero_c: cover property (req_valid && req.op == OP_MASK_CMP ##1 skip);
endmodule // asc_unit
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the arithmetic, shift and compare unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import asc_pkg::*;
	logic      clk;
	logic      nrst;
	logic      req_valid;
	asc_req_t  req;
	logic      req_ready;
	logic      done;
	logic      skip;
	logic      overflow;
	logic      mem_clear;
	asc_word_t res_reg;
	asc_word_t mult_reg;
	asc_word_t [7:1] index_regs;
	int        fails = 0;
	int        comparisons = 0;
	asc_word_t cmp_q;

	asc_seq_model seq (.clk(clk), .req_valid(req_valid), .req(req));
	asc_unit dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .done(done), .skip(skip), .overflow(overflow),
		.mem_clear(mem_clear), .res_reg(res_reg), .mult_reg(mult_reg),
		.index_regs(index_regs));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [59:0] exp, input logic [59:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// adding to a cleared register is exact in ones' complement
	task automatic ld(input asc_word_t a, input asc_word_t q);
		seq.send(OP_ZERO, SEL_RES, SK_NEVER, 30'h0);
		seq.send(OP_ZERO, SEL_MULT, SK_NEVER, 30'h0);
		seq.send(OP_ADD, SEL_RES, SK_NEVER, a);
		seq.send(OP_ADD, SEL_MULT, SK_NEVER, q);
	endtask

	task automatic t_null_zero;
		ld(30'h123, 30'h456);
		seq.send(OP_NULL, SEL_RES, SK_ALWAYS, NULL_WORD);
		chk("done", 1, done);
		chk("ready", 1, req_ready);
		chk("skip", 0, skip);
		chk("regs", {30'h123, 30'h456}, {res_reg, mult_reg});
		seq.send(OP_ZERO, SEL_RES, SK_NEVER, 30'h0);
		chk("regs", {30'h0, 30'h456}, {res_reg, mult_reg});
		seq.send(OP_ZERO, SEL_MEMORY, SK_NEVER, 30'h0);
		chk("mem_clear", 1, mem_clear);
		seq.send(OP_ZERO, SEL_INDEX, SK_NEVER, 30'h0);
		chk("index", 0, index_regs[1]);
		chk("mem_clear", 0, mem_clear);
		$display("test null_zero done");
	endtask

	task automatic t_shift;
		ld(30'h2000_0001, 30'h3);
		// upper operand bits set, count is only the low six
		seq.send(OP_RSHIFT, SEL_RES, SK_NEVER, 30'h3fff_ffc4);
		chk("res", 30'h3e00_0000, res_reg);
		seq.send(OP_LSHIFT, SEL_MULT, SK_NEVER, 30'h3fff_ffdd);
		chk("mult", 30'h2000_0001, mult_reg);
		seq.send(OP_LSHIFT, SEL_DOUBLE, SK_NEVER, 30'h1e);
		chk("dbl", {30'h2000_0001, 30'h3e00_0000}, {res_reg, mult_reg});
		seq.send(OP_RSHIFT, SEL_DOUBLE, SK_NEVER, 30'h1);
		chk("dbl", {30'h3000_0000, 30'h3f00_0000}, {res_reg, mult_reg});
		$display("test shift done");
	endtask

	task automatic t_addsub;
		ld(30'h10, 30'hff);
		seq.send(OP_ADD, SEL_MASKED, SK_NEVER, 30'hf0f);
		chk("res", 30'h1f, res_reg);
		seq.send(OP_SUB, SEL_MASKED, SK_NEVER, 30'hf0f);
		chk("res", 30'h10, res_reg);
		seq.send(OP_SUB, SEL_RES, SK_RES_POS, 30'h4);
		chk("res", 30'hc, res_reg);
		chk("skip", 1, skip);
		seq.send(OP_ZERO, SEL_RES, SK_NEVER, 30'h0);
		seq.send(OP_SUB, SEL_MULT, SK_RES_ZERO, 30'hf);
		chk("mult", 30'hf0, mult_reg);
		chk("skip", 0, skip);
		seq.send(OP_ADD, SEL_MULT, SK_RES_NZ, 30'h10);
		chk("mult", 30'h100, mult_reg);
		chk("skip", 1, skip);
		seq.send(OP_ADD, SEL_RES, SK_MULT_NEG, 30'h1);
		chk("skip", 0, skip);
		$display("test addsub done");
	endtask

	task automatic t_muldiv;
		ld(30'h0, 30'h3);
		seq.send(OP_PRODUCT, SEL_RES, SK_RES_NEG, ~30'h5);
		chk("prod", ~60'hf, {res_reg, mult_reg});
		chk("skip", 0, skip);
		ld(30'h0, 30'h3);
		seq.send(OP_PRODUCT, SEL_RES, SK_RES_POS, 30'h5);
		chk("prod", 60'hf, {res_reg, mult_reg});
		chk("skip", 1, skip);
		ld(30'h0, 30'h11);
		seq.send(OP_DIVIDE, SEL_RES, SK_NO_OVF, 30'h5);
		chk("quo_rem", {30'h2, 30'h3}, {res_reg, mult_reg});
		chk("skip", 1, skip);
		chk("ovf", 0, overflow);
		ld(30'h0, 30'h11);
		seq.send(OP_DIVIDE, SEL_RES, SK_RES_NEG, ~30'h5);
		chk("quo_rem", {~30'h2, ~30'h3}, {res_reg, mult_reg});
		chk("skip", 0, skip);
		ld(30'h0, 30'h11);
		seq.send(OP_DIVIDE, SEL_RES, SK_OVF, 30'h0);
		chk("ovf", 1, overflow);
		chk("skip", 1, skip);
		$display("test muldiv done");
	endtask

	task automatic t_sqrt;
		ld(30'h55, 30'h11);
		seq.send(OP_SQRT, SEL_RES, SK_LEFT_NZ, 30'h0);
		chk("root", {30'h1, 30'h4}, {res_reg, mult_reg});
		chk("skip", 1, skip);
		ld(30'h55, ~30'h10);
		seq.send(OP_SQRT, SEL_RES, SK_LEFT_ZERO, 30'h0);
		chk("root", {30'h0, 30'h4}, {res_reg, mult_reg});
		chk("skip", 1, skip);
		$display("test sqrt done");
	endtask

	task automatic cmp1(input asc_op_t op, input asc_sel_t sel, input asc_skip_t cond,
		input asc_word_t opnd, input logic exp);
		seq.send(op, sel, cond, opnd);
		chk("skip", exp, skip);
		chk("regs", {30'ha, cmp_q}, {res_reg, mult_reg});
	endtask

	task automatic t_compare;
		cmp_q = 30'h14;
		ld(30'ha, 30'h14);
		cmp1(OP_MAG_TEST, SEL_RES, SK_Y_BELOW, 30'ha, 1);
		cmp1(OP_MAG_TEST, SEL_RES, SK_Y_ABOVE, 30'ha, 0);
		cmp1(OP_MAG_TEST, SEL_MULT, SK_Y_ABOVE, 30'h15, 1);
		cmp1(OP_MAG_TEST, SEL_DOUBLE, SK_Y_WINDOW, 30'hf, 1);
		cmp1(OP_MAG_TEST, SEL_DOUBLE, SK_Y_WINDOW, 30'ha, 0);
		cmp1(OP_MAG_TEST, SEL_DOUBLE, SK_Y_OUTSIDE, 30'h15, 1);
		cmp1(OP_MAG_TEST, SEL_DOUBLE, SK_Y_OUTSIDE, 30'hf, 0);
		// masked product 0xa leaves zero, 0xe leaves a negative value
		// through negative zero to a multiplier of 0xe
		seq.send(OP_ADD, SEL_MULT, SK_NEVER, ~30'h14);
		seq.send(OP_ADD, SEL_MULT, SK_NEVER, 30'he);
		cmp_q = 30'he;
		cmp1(OP_MASK_CMP, SEL_MASKED, SK_RES_ZERO, 30'h2a, 1);
		cmp1(OP_MASK_CMP, SEL_MASKED, SK_RES_NEG, 30'h3e, 1);
		$display("test compare done");
	endtask

	initial begin
		nrst = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_null_zero();
		t_shift();
		t_addsub();
		t_muldiv();
		t_sqrt();
		t_compare();
		print_verdict();
	end

	// 77 requests of two cycles each, with ample room
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
